// >>> hdl/rmc_pkg.sv
/*
 * Constants for the radio mode controller: mode encodings and timing figures.
 * Assumes a 100 MHz reference clock; the cycle counts are derived from it.
 */
package rmc_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ         = 100;
    localparam int PD2STBY_US      = 150;   // Power down to standby, longest.
    localparam int STBY2ACT_US     = 130;   // Standby to TX or RX, longest.
    localparam int RPD_PERSIST_US  = 40;    // Power detect persistence, least.
    localparam int CE_PULSE_US     = 10;    // Least chip-enable pulse.
    localparam int TX_LIMIT_US     = 4000;  // Longest stay in TX.
    localparam int PD2STBY_CYC     = PD2STBY_US * CLK_MHZ;
    localparam int STBY2ACT_CYC    = STBY2ACT_US * CLK_MHZ;
    localparam int RPD_PERSIST_CYC = RPD_PERSIST_US * CLK_MHZ;
    localparam int CE_PULSE_CYC    = CE_PULSE_US * CLK_MHZ;
    localparam int TX_LIMIT_CYC    = TX_LIMIT_US * CLK_MHZ;
    localparam int CNT_W           = 20;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic RPD_RST = 1'b0;

    // ------------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        RMC_POWER_DOWN = 3'b000,
        RMC_PD_SETTLE  = 3'b001,
        RMC_STANDBY_1  = 3'b010,
        RMC_STANDBY_2  = 3'b011,
        RMC_SETTLE     = 3'b100,
        RMC_RX         = 3'b101,
        RMC_TX         = 3'b110
    } rmc_mode_t;

endpackage

// >>> hdl/rmc_radio_mode_controller.sv
/*
 * Operating-mode sequencer of the radio core: power down, standby-I,
 * standby_clocked_mode, RX and TX, plus RX packet acceptance and power detect.
 * Assumes all inputs are synchronous to REF_CLK_I and that the packet
 * engine pulses its done and valid strobes for one cycle each.
 */
// What this block does
// - After reset the block settles in power down.
// - Power down keeps register values and SPI access, gated by select.
// - Clearing power_up_bit forces power down from any mode.
// - Setting power_up_bit in power down leads to standby-I.
// - RX needs chip enable; dropping it returns to standby-I, from TX only once the packet ends.
// - Transmitter role, chip enable high, empty TX FIFO gives standby_clocked_mode.
// - In standby_clocked_mode a new packet starts the synthesizer, sent after 130 us.
// - Both standby modes keep registers and keep SPI usable.
// - Power up, receiver role and chip enable all high enter RX.
// - RX accepts only address-matched, CRC-good packets into a free slot.
// - A valid packet is dropped when all RX FIFO slots are full.
// - RX holds until host selects standby-I or power down, or hands over to TX with a payload waiting.
// - Power flag rises after the detector stays high for 40 us.
// - TX needs power up, transmitter role, payload and a 10 us enable pulse; the block takes one enable cycle.
// - TX finishes its packet, then standby-I if enable low, else FIFO decides.
// - With enable high, next packet is sent or standby_clocked_mode entered.
// - With the protocol engine enabled, no single packet keeps TX beyond 4 ms.
// - Enable held high drains the TX FIFO, retries included, while refilled.
// - In standby_clocked_mode transmission starts when SPI select rises after upload.
// - One 10 us enable pulse sends exactly one packet, then standby-I.
// - Standby to TX or RX takes at most 130 us.
// - Switching TX and RX directly takes the same settling time.
// - Power down to standby completes within 150 us.
module rmc_radio_mode_controller #(
    parameter int PD2STBY_CYC  = rmc_pkg::PD2STBY_CYC,
    parameter int STBY2ACT_CYC = rmc_pkg::STBY2ACT_CYC,
    parameter int RPD_CYC      = rmc_pkg::RPD_PERSIST_CYC,
    parameter int TX_LIMIT_CYC = rmc_pkg::TX_LIMIT_CYC
) (
    // Clock and reset.
    input  wire logic REF_CLK_I,
    input  wire logic RST_N_I,
    // Control bits from the microcontroller.
    input  wire logic POWER_UP_BIT_I,
    input  wire logic PRIMARY_RECEIVER_BIT_I,
    input  wire logic RADIO_CHIP_ENABLE_I,
    input  wire logic SPI_SELECT_I,
    input  wire logic AUTO_PROTOCOL_EN_I,
    // FIFO and packet engine status.
    input  wire logic TX_FIFO_EMPTY_I,
    input  wire logic RX_FIFO_FULL_I,
    input  wire logic TX_PACKET_DONE_I,
    input  wire logic RX_PACKET_END_I,
    input  wire logic RX_ADDR_MATCH_I,
    input  wire logic RX_CRC_OK_I,
    input  wire logic RAW_POWER_DETECT_I,
    // Mode and status outputs.
    output logic [2:0] MODE_O,
    output logic       SPI_ENABLE_O,
    output logic       CLK_BUFFERS_ON_O,
    output logic       SYNTH_ON_O,
    output logic       TX_ACTIVE_O,
    output logic       RX_ACTIVE_O,
    output logic       RX_FIFO_WRITE_O,
    output logic       RX_PACKET_DROP_O,
    output logic       RECEIVED_POWER_FLAG_O,
    output logic       TX_TIMEOUT_O
);

    // ------------------------------------------------------------------
    // State and counters
    // ------------------------------------------------------------------
    rmc_pkg::rmc_mode_t mode_reg;
    rmc_pkg::rmc_mode_t mode_next;
    logic                      target_rx_reg;
    logic                      target_rx_next;
    logic [rmc_pkg::CNT_W-1:0] settle_cnt_reg;
    logic [rmc_pkg::CNT_W-1:0] rpd_cnt_reg;
    logic [rmc_pkg::CNT_W-1:0] tx_cnt_reg;
    logic                      select_d_reg;
    logic                      upload_seen_reg;
    logic                      settle_done;
    logic                      tx_limit_hit;
    logic                      go_tx;
    logic                      upload_start;

    // Last cycle of each interval; the counters share one width, sized for the longest.
    localparam logic [rmc_pkg::CNT_W-1:0] PD_LAST  = rmc_pkg::CNT_W'(PD2STBY_CYC - 1);
    localparam logic [rmc_pkg::CNT_W-1:0] ACT_LAST = rmc_pkg::CNT_W'(STBY2ACT_CYC - 1);
    localparam logic [rmc_pkg::CNT_W-1:0] RPD_LAST = rmc_pkg::CNT_W'(RPD_CYC - 1);
    localparam logic [rmc_pkg::CNT_W-1:0] TX_LAST  = rmc_pkg::CNT_W'(TX_LIMIT_CYC - 1);

    // Settling ends on the last cycle of whichever interval applies.
    assign settle_done = (mode_reg == rmc_pkg::RMC_PD_SETTLE && settle_cnt_reg == PD_LAST) ||
                         (mode_reg == rmc_pkg::RMC_SETTLE && settle_cnt_reg == ACT_LAST);
    // The limit guard only acts with the protocol engine on; without it the host owns it.
    assign tx_limit_hit = AUTO_PROTOCOL_EN_I && tx_cnt_reg == TX_LAST;
    // A payload waiting with the transmitter role and chip enable makes a TX request.
    assign go_tx = !PRIMARY_RECEIVER_BIT_I && RADIO_CHIP_ENABLE_I && !TX_FIFO_EMPTY_I;
    // A select rise ends an upload; a FIFO flag that turns on at that same edge still counts,
    // otherwise the rise would be missed and standby_clocked_mode would wait for the next upload.
    assign upload_start = SPI_SELECT_I && !select_d_reg &&
                          (upload_seen_reg || !TX_FIFO_EMPTY_I);

    // ------------------------------------------------------------------
    // Mode sequencing
    // ------------------------------------------------------------------
    // Next-mode decision; power_up_bit low overrides everything else.
    always_comb begin
        mode_next      = mode_reg;
        target_rx_next = target_rx_reg;
        if (!POWER_UP_BIT_I) begin
            mode_next = rmc_pkg::RMC_POWER_DOWN;
        end else begin
            unique case (mode_reg)
                rmc_pkg::RMC_POWER_DOWN: begin
                    mode_next = rmc_pkg::RMC_PD_SETTLE;
                end
                rmc_pkg::RMC_PD_SETTLE: begin
                    if (settle_done) begin
                        mode_next = rmc_pkg::RMC_STANDBY_1;
                    end
                end
                rmc_pkg::RMC_STANDBY_1: begin
                    if (RADIO_CHIP_ENABLE_I && PRIMARY_RECEIVER_BIT_I) begin
                        mode_next      = rmc_pkg::RMC_SETTLE;
                        target_rx_next = 1'b1;
                    end else if (go_tx) begin
                        mode_next      = rmc_pkg::RMC_SETTLE;
                        target_rx_next = 1'b0;
                    end else if (RADIO_CHIP_ENABLE_I && !PRIMARY_RECEIVER_BIT_I) begin
                        mode_next = rmc_pkg::RMC_STANDBY_2;
                    end
                end
                rmc_pkg::RMC_STANDBY_2: begin
                    if (!RADIO_CHIP_ENABLE_I) begin
                        mode_next = rmc_pkg::RMC_STANDBY_1;
                    end else if (PRIMARY_RECEIVER_BIT_I) begin
                        mode_next      = rmc_pkg::RMC_SETTLE;
                        target_rx_next = 1'b1;
                    end else if (upload_start) begin
                        mode_next      = rmc_pkg::RMC_SETTLE;
                        target_rx_next = 1'b0;
                    end
                end
                rmc_pkg::RMC_SETTLE: begin
                    // Toward TX a lost enable is ignored, so a short pulse still sends a packet.
                    if (!RADIO_CHIP_ENABLE_I && target_rx_reg) begin
                        mode_next = rmc_pkg::RMC_STANDBY_1;
                    end else if (settle_done) begin
                        mode_next = target_rx_reg ? rmc_pkg::RMC_RX : rmc_pkg::RMC_TX;
                    end
                end
                rmc_pkg::RMC_RX: begin
                    // Receiving goes on until the host drops enable or hands over to TX.
                    if (!RADIO_CHIP_ENABLE_I) begin
                        mode_next = rmc_pkg::RMC_STANDBY_1;
                    end else if (!PRIMARY_RECEIVER_BIT_I && !TX_FIFO_EMPTY_I) begin
                        mode_next      = rmc_pkg::RMC_SETTLE;
                        target_rx_next = 1'b0;
                    end
                end
                rmc_pkg::RMC_TX: begin
                    // The guard is tested first so that a hung engine cannot hold TX.
                    if (tx_limit_hit) begin
                        mode_next = rmc_pkg::RMC_STANDBY_1;
                    end else if (TX_PACKET_DONE_I) begin
                        if (!RADIO_CHIP_ENABLE_I) begin
                            mode_next = rmc_pkg::RMC_STANDBY_1;
                        end else if (PRIMARY_RECEIVER_BIT_I) begin
                            mode_next      = rmc_pkg::RMC_SETTLE;
                            target_rx_next = 1'b1;
                        end else if (TX_FIFO_EMPTY_I) begin
                            mode_next = rmc_pkg::RMC_STANDBY_2;
                        end
                        // Otherwise stay in TX and send the next packet.
                    end
                end
                default: begin
                    mode_next = rmc_pkg::RMC_POWER_DOWN;
                end
            endcase
        end
    end

    // Mode register; reset lands in power down.
    // The receive target sits beside it so that settling knows where to go.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mode_reg      <= rmc_pkg::RMC_POWER_DOWN;
            target_rx_reg <= 1'b0;
        end else begin
            mode_reg      <= mode_next;
            target_rx_reg <= target_rx_next;
        end
    end

    // Settling counter restarts on every change of mode.
    // Only the settle states read it, so its wrap in the steady modes is harmless.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            settle_cnt_reg <= '0;
        end else if (mode_next != mode_reg) begin
            settle_cnt_reg <= '0;
        end else begin
            settle_cnt_reg <= settle_cnt_reg + 1'b1;
        end
    end

    // Time spent in TX, cleared on every packet boundary and outside TX.
    // It holds at the limit, so the timeout pulse cannot repeat.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tx_cnt_reg <= '0;
        end else if (mode_reg != rmc_pkg::RMC_TX || TX_PACKET_DONE_I) begin
            tx_cnt_reg <= '0;
        end else if (!tx_limit_hit) begin
            tx_cnt_reg <= tx_cnt_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Standby_clocked_mode upload tracking
    // ------------------------------------------------------------------
    // An upload counts once the FIFO holds data; the select rise then starts it.
    // A select rise with nothing uploaded is ignored, so plain register access starts nothing.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            select_d_reg    <= 1'b0;
            upload_seen_reg <= 1'b0;
        end else begin
            select_d_reg <= SPI_SELECT_I;
            if (mode_reg != rmc_pkg::RMC_STANDBY_2) begin
                upload_seen_reg <= 1'b0;
            end else if (!TX_FIFO_EMPTY_I) begin
                upload_seen_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // RX acceptance and power detect
    // ------------------------------------------------------------------
    // Only a packet finished in RX proper counts; settling accepts nothing.
    // Both pulses share one qualifier and differ only in the full flag, so never both.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RX_FIFO_WRITE_O  <= 1'b0;
            RX_PACKET_DROP_O <= 1'b0;
        end else begin
            RX_FIFO_WRITE_O  <= mode_reg == rmc_pkg::RMC_RX && RX_PACKET_END_I &&
                                RX_ADDR_MATCH_I && RX_CRC_OK_I && !RX_FIFO_FULL_I;
            RX_PACKET_DROP_O <= mode_reg == rmc_pkg::RMC_RX && RX_PACKET_END_I &&
                                RX_ADDR_MATCH_I && RX_CRC_OK_I && RX_FIFO_FULL_I;
        end
    end

    // The detector must stay high unbroken; a single low sample restarts the wait.
    // Outside RX the flag keeps its value, so it can still be read after receiving.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rpd_cnt_reg           <= '0;
            RECEIVED_POWER_FLAG_O <= rmc_pkg::RPD_RST;
        end else if (mode_reg != rmc_pkg::RMC_RX || !RAW_POWER_DETECT_I) begin
            rpd_cnt_reg <= '0;
            if (mode_reg == rmc_pkg::RMC_RX) begin
                RECEIVED_POWER_FLAG_O <= 1'b0;
            end
        end else if (rpd_cnt_reg == RPD_LAST) begin
            RECEIVED_POWER_FLAG_O <= 1'b1;
        end else begin
            rpd_cnt_reg <= rpd_cnt_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Mode outputs
    // ------------------------------------------------------------------
    // Registered from the next mode so outputs track the mode register exactly.
    // Decoding mode_next costs a little logic per output but adds no cycle of lag.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            MODE_O           <= rmc_pkg::RMC_POWER_DOWN;
            SPI_ENABLE_O     <= 1'b0;
            CLK_BUFFERS_ON_O <= 1'b0;
            SYNTH_ON_O       <= 1'b0;
            TX_ACTIVE_O      <= 1'b0;
            RX_ACTIVE_O      <= 1'b0;
            TX_TIMEOUT_O     <= 1'b0;
        end else begin
            MODE_O           <= mode_next;
            // Registers are never cleared by mode; SPI follows only the select bit.
            SPI_ENABLE_O     <= SPI_SELECT_I;
            CLK_BUFFERS_ON_O <= mode_next == rmc_pkg::RMC_STANDBY_2 ||
                                mode_next == rmc_pkg::RMC_SETTLE ||
                                mode_next == rmc_pkg::RMC_RX ||
                                mode_next == rmc_pkg::RMC_TX;
            SYNTH_ON_O       <= mode_next == rmc_pkg::RMC_SETTLE ||
                                mode_next == rmc_pkg::RMC_RX ||
                                mode_next == rmc_pkg::RMC_TX;
            TX_ACTIVE_O      <= mode_next == rmc_pkg::RMC_TX;
            RX_ACTIVE_O      <= mode_next == rmc_pkg::RMC_RX;
            TX_TIMEOUT_O     <= mode_reg == rmc_pkg::RMC_TX && tx_limit_hit;
        end
    end

endmodule

// >>> verification/rmc_engine_model.sv
/*
 * Behavioural packet engine beside the mode controller: ends each packet.
 * Assumes it shares the controller clock and reset.
 */
module rmc_engine_model #(
    parameter int DONE_DLY = 6
) (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Controller status and test control.
    input  wire logic tx_active_i,
    input  wire logic hang_i,
    // Packet finished strobe.
    output logic      tx_done_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt_reg;

    // ------------------------------------------------------------------
    // Packet timer
    // ------------------------------------------------------------------
    // A hung engine never ends its packet, so the TX guard must act.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg   <= 4'h0;
            tx_done_o <= 1'b0;
        end else begin
            tx_done_o <= 1'b0;
            if (!tx_active_i) begin
                cnt_reg <= 4'h0;
            end else if (cnt_reg == 4'(DONE_DLY) && !hang_i) begin
                tx_done_o <= 1'b1;
                cnt_reg   <= 4'h0;
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end
endmodule

// >>> verification/rmc_radio_mode_controller_checker.sv
/*
 * Timing checks on the mode controller ports.
 * Assumes one clock domain and the asynchronous active-low reset.
 */
module rmc_mode_checker #(
    parameter int STBY2ACT_CYC = 8,
    parameter int RPD_CYC      = 5
) (
    // Clock and reset.
    input wire logic       REF_CLK_I,
    input wire logic       RST_N_I,
    // Inputs watched.
    input wire logic       POWER_UP_BIT_I,
    input wire logic       PRIMARY_RECEIVER_BIT_I,
    input wire logic       RADIO_CHIP_ENABLE_I,
    input wire logic       TX_FIFO_EMPTY_I,
    input wire logic       RX_FIFO_FULL_I,
    input wire logic       TX_PACKET_DONE_I,
    input wire logic       RX_PACKET_END_I,
    input wire logic       RX_ADDR_MATCH_I,
    input wire logic       RX_CRC_OK_I,
    input wire logic       RAW_POWER_DETECT_I,
    // Outputs watched.
    input wire logic [2:0] MODE_O,
    input wire logic       RX_FIFO_WRITE_O,
    input wire logic       RX_PACKET_DROP_O,
    input wire logic       RECEIVED_POWER_FLAG_O
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic [15:0] set_cnt_reg;
    logic [15:0] hi_cnt_reg;
    logic        pkt_ok;

    // ------------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------------
    // Settle length and run of detector highs while receiving.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            set_cnt_reg <= 16'h0;
            hi_cnt_reg  <= 16'h0;
        end else begin
            set_cnt_reg <= (MODE_O == 3'h4) ? set_cnt_reg + 16'h1 : 16'h0;
            hi_cnt_reg  <= (MODE_O == 3'h5 && RAW_POWER_DETECT_I) ? hi_cnt_reg + 16'h1 : 16'h0;
        end
    end
    // A finished packet that passes both the address and the CRC test.
    assign pkt_ok = RX_PACKET_END_I && RX_ADDR_MATCH_I && RX_CRC_OK_I;

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_pd_forced; !POWER_UP_BIT_I |=> MODE_O == 3'h0; endproperty
    a_pd_forced: assert property (p_pd_forced) else $error("power down not forced");
    property p_wake; MODE_O == 3'h0 && POWER_UP_BIT_I |=> MODE_O == 3'h1; endproperty
    a_wake: assert property (p_wake) else $error("no wake from power down");
    property p_rx_write;
        MODE_O == 3'h5 && pkt_ok && !RX_FIFO_FULL_I |=> RX_FIFO_WRITE_O && !RX_PACKET_DROP_O;
    endproperty
    a_rx_write: assert property (p_rx_write) else $error("good packet not stored");
    property p_rx_drop;
        MODE_O == 3'h5 && pkt_ok && RX_FIFO_FULL_I |=> RX_PACKET_DROP_O && !RX_FIFO_WRITE_O;
    endproperty
    a_rx_drop: assert property (p_rx_drop) else $error("full fifo packet not dropped");
    property p_bad_pkt;
        RX_PACKET_END_I && !(RX_ADDR_MATCH_I && RX_CRC_OK_I) |=> !RX_FIFO_WRITE_O;
    endproperty
    a_bad_pkt: assert property (p_bad_pkt) else $error("bad packet stored");
    property p_ce_drop;
        MODE_O == 3'h5 && !RADIO_CHIP_ENABLE_I && POWER_UP_BIT_I |=> MODE_O == 3'h2;
    endproperty
    a_ce_drop: assert property (p_ce_drop) else $error("rx kept without enable");
    property p_done_ce_low;
        MODE_O == 3'h6 && TX_PACKET_DONE_I && !RADIO_CHIP_ENABLE_I && POWER_UP_BIT_I
            |=> MODE_O == 3'h2;
    endproperty
    a_done_ce_low: assert property (p_done_ce_low) else $error("no standby-I");
    property p_done_empty;
        MODE_O == 3'h6 && TX_PACKET_DONE_I && RADIO_CHIP_ENABLE_I && POWER_UP_BIT_I
            && !PRIMARY_RECEIVER_BIT_I && TX_FIFO_EMPTY_I |=> MODE_O == 3'h3;
    endproperty
    a_done_empty: assert property (p_done_empty) else $error("no standby_clocked_mode");
    property p_settle_quiet; MODE_O == 3'h4 |=> !RX_FIFO_WRITE_O; endproperty
    a_settle_quiet: assert property (p_settle_quiet) else $error("rx while settling");
    property p_settle_len; set_cnt_reg <= 16'(STBY2ACT_CYC); endproperty
    a_settle_len: assert property (p_settle_len) else $error("settling too long");
    property p_rpd; $rose(RECEIVED_POWER_FLAG_O) |-> hi_cnt_reg >= 16'(RPD_CYC); endproperty
    a_rpd: assert property (p_rpd) else $error("power flag too early");
endmodule

bind rmc_radio_mode_controller rmc_mode_checker #(
    .STBY2ACT_CYC(STBY2ACT_CYC), .RPD_CYC(RPD_CYC)
) rmc_mode_checker_i (
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .POWER_UP_BIT_I(POWER_UP_BIT_I),
    .PRIMARY_RECEIVER_BIT_I(PRIMARY_RECEIVER_BIT_I), .RADIO_CHIP_ENABLE_I(RADIO_CHIP_ENABLE_I),
    .TX_FIFO_EMPTY_I(TX_FIFO_EMPTY_I), .RX_FIFO_FULL_I(RX_FIFO_FULL_I),
    .TX_PACKET_DONE_I(TX_PACKET_DONE_I), .RX_PACKET_END_I(RX_PACKET_END_I),
    .RX_ADDR_MATCH_I(RX_ADDR_MATCH_I), .RX_CRC_OK_I(RX_CRC_OK_I),
    .RAW_POWER_DETECT_I(RAW_POWER_DETECT_I), .MODE_O(MODE_O), .RX_FIFO_WRITE_O(RX_FIFO_WRITE_O),
    .RX_PACKET_DROP_O(RX_PACKET_DROP_O), .RECEIVED_POWER_FLAG_O(RECEIVED_POWER_FLAG_O)
);

// >>> verification/rmc_radio_mode_controller_test.sv
/*
 * Self-checking bench of the mode controller with short timing parameters.
 * Assumes the engine model and the bound checker are compiled alongside.
 */
module rmc_radio_mode_controller_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, pu = 0, prx = 0, ce = 0, spi = 1, auto_en = 0, hang = 0;
    logic empty = 1, full = 0, done, pend = 0, match = 1, crc = 1, raw = 0;
    logic [2:0] mode;
    logic spi_en, bufs, synth, tx_act, rx_act, wr, drop, flag, tmo;
    int errors = 0, check_count = 0;

    // Short counts keep the run brief; expectations use the same values.
    rmc_radio_mode_controller #(.PD2STBY_CYC(8), .STBY2ACT_CYC(8), .RPD_CYC(5),
        .TX_LIMIT_CYC(50)) rmc_radio_mode_controller_i (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .POWER_UP_BIT_I(pu), .PRIMARY_RECEIVER_BIT_I(prx),
        .RADIO_CHIP_ENABLE_I(ce), .SPI_SELECT_I(spi), .AUTO_PROTOCOL_EN_I(auto_en),
        .TX_FIFO_EMPTY_I(empty), .RX_FIFO_FULL_I(full), .TX_PACKET_DONE_I(done),
        .RX_PACKET_END_I(pend), .RX_ADDR_MATCH_I(match), .RX_CRC_OK_I(crc),
        .RAW_POWER_DETECT_I(raw), .MODE_O(mode), .SPI_ENABLE_O(spi_en),
        .CLK_BUFFERS_ON_O(bufs), .SYNTH_ON_O(synth), .TX_ACTIVE_O(tx_act),
        .RX_ACTIVE_O(rx_act), .RX_FIFO_WRITE_O(wr), .RX_PACKET_DROP_O(drop),
        .RECEIVED_POWER_FLAG_O(flag), .TX_TIMEOUT_O(tmo));
    rmc_engine_model #(.DONE_DLY(6)) rmc_engine_model_i (
        .clk_i(clk), .rst_n_i(rst_n), .tx_active_i(tx_act), .hang_i(hang), .tx_done_o(done));

    always #5 clk = ~clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [2:0] got, input logic [2:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Inputs move one nanosecond after the edge, away from sampling.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_mode(input logic [2:0] m);
        for (int k = 0; k < 40 && mode !== m; k++) cyc(1);
        chk("mode", mode, m);
    endtask
    task automatic results;
        if (errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_power_up;
        chk("reset mode", mode, 3'h0);
        spi = 0;
        cyc(2);
        chk("spi in power down", 3'(spi_en), 3'h0);
        spi = 1;
        cyc(1);
        chk("spi follows select", 3'(spi_en), 3'h1);
        pu = 1;
        cyc(1);
        chk("wake", mode, 3'h1);
        cyc(7);
        chk("still settling", mode, 3'h1);
        cyc(1);
        chk("standby-I", mode, 3'h2);
        chk("spi in standby", 3'(spi_en), 3'h1);
    endtask
    task automatic t_rx;
        prx = 1;
        ce = 1;
        cyc(1);
        chk("rx settle", mode, 3'h4);
        chk("synth in settle", 3'({synth, rx_act}), 3'h2);
        cyc(8);
        chk("rx entered", mode, 3'h5);
        chk("rx active", 3'({tx_act, rx_act}), 3'h1);
        pend = 1;
        cyc(1);
        chk("stored", 3'(wr), 3'h1);
        crc = 0;
        cyc(1);
        chk("bad crc", 3'(wr), 3'h0);
        crc = 1;
        full = 1;
        cyc(1);
        chk("dropped", 3'({drop, wr}), 3'h2);
        pend = 0;
        full = 0;
        raw = 1;
        cyc(4);
        chk("flag early", 3'(flag), 3'h0);
        cyc(1);
        chk("flag set", 3'(flag), 3'h1);
        chk("rx held", mode, 3'h5);
        ce = 0;
        raw = 0;
        cyc(1);
        chk("rx to standby-I", mode, 3'h2);
    endtask
    task automatic t_tx;
        prx = 0;
        empty = 0;
        ce = 1;
        cyc(2);
        ce = 0;
        wait_mode(3'h6);
        chk("tx active", 3'({tx_act, rx_act}), 3'h2);
        wait_mode(3'h2);
        ce = 1;
        wait_mode(3'h6);
        empty = 1;
        wait_mode(3'h3);
        chk("buffers and synth", 3'({bufs, synth}), 3'h2);
        spi = 0;
        empty = 0;
        cyc(2);
        chk("waits for select", mode, 3'h3);
        spi = 1;
        wait_mode(3'h4);
        wait_mode(3'h6);
        prx = 1;
        wait_mode(3'h4);
        cyc(7);
        chk("tx to rx settle", mode, 3'h4);
        cyc(1);
        chk("tx to rx", mode, 3'h5);
        pu = 0;
        ce = 0;
        cyc(1);
        chk("forced down", mode, 3'h0);
    endtask
    task automatic t_guard;
        auto_en = 1;
        hang = 1;
        prx = 0;
        pu = 1;
        wait_mode(3'h2);
        ce = 1;
        wait_mode(3'h6);
        ce = 0;
        for (int k = 0; k < 60 && tmo !== 1'b1; k++) cyc(1);
        chk("tx guard", 3'(tmo), 3'h1);
        wait_mode(3'h2);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        #1 rst_n = 1;
        t_power_up();
        t_rx();
        t_tx();
        t_guard();
        results();
    end
    // Cuts a hang well beyond the few hundred cycles the run needs.
    initial begin
        #100000;
        errors++;
        results();
    end
endmodule
